/* File: joy_map.svh */
`ifndef JOY_MAP_SVH
`define JOY_MAP_SVH
`define CTRL_OFS      8'h0F
`define X_OFS         8'h10
`define Y_OFS         8'h11
`define SCALE_OFS     8'h2D
`define CTRL_RST      8'hF0
`define SCALE_RST     8'h00
`define TGT_ADDR_BASE 7'h40
`define CTRL_IDLE_BIT 7
`define CTRL_TB_LSB   4
`define CTRL_MODE_BIT 2
`define CTRL_SOFT_BIT 1
`define CLK_MHZ       100
`define TCONV_US      450
`define TPUA_US       1000
`define TB_UNIT_US    20000
`define SYNC_GUARD    16
`define TCONV_CYC     (`TCONV_US * `CLK_MHZ)
`define TPUA_CYC      (`TPUA_US * `CLK_MHZ)
`define TB_UNIT_CYC   (`TB_UNIT_US * `CLK_MHZ)
`endif

/* File: joy_pkg.sv */
package joy_pkg;
   typedef enum logic [2:0] {
      M_START = 3'b001,
      M_MEAS  = 3'b010,
      M_WAIT  = 3'b100
   } meas_state_type;
   typedef enum logic [4:0] {
      B_IDLE = 5'b00001,
      B_RX   = 5'b00010,
      B_RACK = 5'b00100,
      B_TX   = 5'b01000,
      B_TACK = 5'b10000
   } bus_state_type;
endpackage

/* File: joy_encoder_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "joy_map.svh"
module joy_encoder_ctrl #(
   parameter int START_CYC   = `TPUA_CYC - `TCONV_CYC,
   parameter int CONV_CYC    = `TCONV_CYC - `SYNC_GUARD,
   parameter int TB_UNIT_CYC = `TB_UNIT_CYC,
   parameter logic [7:0] WAKE_LIMIT = 8'h0A
) (
   input  wire logic       core_clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       hw_clear_low_in,
   input  wire logic       addr_sel_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   output logic            irq_out_low_out,
   output logic            irq_out_low_oe_out,
   input  wire logic [7:0] x_meas_in,
   input  wire logic [7:0] y_meas_in,
   output logic            meas_busy_out
);
   // Pin synchronisers; stage one feeds stage two only.
   logic [2:0] scl_s_q, sda_s_q;
   logic [1:0] clr_s_q, adr_s_q;
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         clr_s_q <= 2'h3;
         adr_s_q <= 2'h0;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_in};
         sda_s_q <= {sda_s_q[1:0], sda_in};
         clr_s_q <= {clr_s_q[0], hw_clear_low_in};
         adr_s_q <= {adr_s_q[0], addr_sel_in};
      end
   end
   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise  = scl_s_q[1] & ~scl_s_q[2];
   assign scl_fall  = ~scl_s_q[1] & scl_s_q[2];
   assign bus_start = scl_s_q[1] & scl_s_q[2] & sda_s_q[2] & ~sda_s_q[1];
   assign bus_stop  = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[2] & sda_s_q[1];

   // The async reset is the one-shot power-on clear; a supply dip cannot reach it.
   logic soft_clr_q, clear;
   assign clear = ~clr_s_q[1] | soft_clr_q;

   logic [7:0] ctrl_q, scale_q, x_q, y_q;
   logic       ready_q, flag_q, irq_q;
   joy_pkg::meas_state_type mst_q;
   logic [31:0] cnt_q;
   logic        meas_req_q, new_data;
   logic [31:0] tb_limit;
   assign tb_limit = TB_UNIT_CYC * (32'(ctrl_q[`CTRL_TB_LSB +: 3]) + 32'h1);
   assign new_data = (mst_q == joy_pkg::M_MEAS) && (cnt_q == 32'(CONV_CYC - 1));

   // Start-up, one measurement, then wait for the timebase or a read.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mst_q   <= joy_pkg::M_START;
         cnt_q   <= 32'h0;
         ready_q <= 1'b0;
      end else if (clear) begin
         mst_q   <= joy_pkg::M_START;
         cnt_q   <= 32'h0;
         ready_q <= 1'b0;
      end else begin
         case (mst_q)
            joy_pkg::M_START: begin
               if (cnt_q >= 32'(START_CYC - 1)) begin
                  mst_q   <= joy_pkg::M_MEAS;
                  cnt_q   <= 32'h0;
                  ready_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            joy_pkg::M_MEAS: begin
               if (new_data) begin
                  mst_q <= joy_pkg::M_WAIT;
                  cnt_q <= 32'h0;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            joy_pkg::M_WAIT: begin
               if (meas_req_q || (!ctrl_q[`CTRL_IDLE_BIT] && cnt_q >= tb_limit - 32'h1)) begin
                  mst_q <= joy_pkg::M_MEAS;
                  cnt_q <= 32'h0;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            default: begin
               mst_q <= joy_pkg::M_START;
               cnt_q <= 32'h0;
            end
         endcase
      end
   end
   assign meas_busy_out = (mst_q == joy_pkg::M_MEAS);

   // Coordinates are taken as signed bytes straight from the converter.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         x_q <= 8'h00;
         y_q <= 8'h00;
      end else if (clear) begin
         x_q <= 8'h00;
         y_q <= 8'h00;
      end else if (new_data) begin
         x_q <= x_meas_in;
         y_q <= y_meas_in;
      end
   end

   // Target side of the serial bus.
   joy_pkg::bus_state_type bst_q;
   logic [7:0] sh_q, ptr_q;
   logic [3:0] bit_q;
   logic       addr_ph_q, ptr_ph_q, rw_q, oe_q, coord_rd_q, ack_q;
   logic       wr_en, y_read, load_tx;
   logic [7:0] rd_byte;
   logic [6:0] my_addr;
   assign my_addr = `TGT_ADDR_BASE | {6'h00, adr_s_q[1]};
   assign wr_en   = (bst_q == joy_pkg::B_RX) && scl_fall && bit_q == 4'h8
                    && !addr_ph_q && !ptr_ph_q;
   assign load_tx = scl_fall && rw_q && ((bst_q == joy_pkg::B_RACK) ||
                    (bst_q == joy_pkg::B_TACK && ack_q));
   assign y_read  = load_tx && ptr_q == `Y_OFS;

   always_comb begin
      case (ptr_q)
         `CTRL_OFS:  rd_byte = ready_q ? {ctrl_q[7:1], flag_q} : 8'h00;
         `X_OFS:     rd_byte = x_q;
         `Y_OFS:     rd_byte = y_q;
         `SCALE_OFS: rd_byte = scale_q;
         default:    rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bst_q      <= joy_pkg::B_IDLE;
         sh_q       <= 8'h00;
         ptr_q      <= 8'h00;
         bit_q      <= 4'h0;
         addr_ph_q  <= 1'b0;
         ptr_ph_q   <= 1'b0;
         rw_q       <= 1'b0;
         oe_q       <= 1'b0;
         coord_rd_q <= 1'b0;
         ack_q      <= 1'b0;
         meas_req_q <= 1'b0;
      end else begin
         meas_req_q <= 1'b0;
         if (bus_start) begin
            bst_q     <= joy_pkg::B_RX;
            bit_q     <= 4'h0;
            addr_ph_q <= 1'b1;
            oe_q      <= 1'b0;
         end else if (bus_stop) begin
            bst_q      <= joy_pkg::B_IDLE;
            oe_q       <= 1'b0;
            meas_req_q <= coord_rd_q;
            coord_rd_q <= 1'b0;
         end else begin
            case (bst_q)
               joy_pkg::B_RX: begin
                  if (scl_rise) begin
                     sh_q  <= {sh_q[6:0], sda_s_q[1]};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     if (addr_ph_q) begin
                        if (sh_q[7:1] == my_addr) begin
                           bst_q    <= joy_pkg::B_RACK;
                           oe_q     <= 1'b1;
                           rw_q     <= sh_q[0];
                           ptr_ph_q <= ~sh_q[0];
                        end else begin
                           bst_q <= joy_pkg::B_IDLE;
                        end
                        addr_ph_q <= 1'b0;
                     end else begin
                        bst_q    <= joy_pkg::B_RACK;
                        oe_q     <= 1'b1;
                        ptr_ph_q <= 1'b0;
                        ptr_q    <= ptr_ph_q ? sh_q : ptr_q + 8'h01;
                     end
                  end
               end
               joy_pkg::B_RACK: begin
                  if (scl_fall) begin
                     bit_q <= 4'h0;
                     if (rw_q) begin
                        bst_q <= joy_pkg::B_TX;
                        sh_q  <= rd_byte;
                        oe_q  <= ~rd_byte[7];
                        ptr_q <= ptr_q + 8'h01;
                        if (ptr_q == `X_OFS || ptr_q == `Y_OFS) begin
                           coord_rd_q <= 1'b1;
                        end
                     end else begin
                        bst_q <= joy_pkg::B_RX;
                        oe_q  <= 1'b0;
                     end
                  end
               end
               joy_pkg::B_TX: begin
                  if (scl_rise) begin
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_q == 4'h8) begin
                        bst_q <= joy_pkg::B_TACK;
                        oe_q  <= 1'b0;
                     end else begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        oe_q <= ~sh_q[6];
                     end
                  end
               end
               joy_pkg::B_TACK: begin
                  if (scl_rise) begin
                     ack_q <= ~sda_s_q[1];
                  end else if (scl_fall) begin
                     bit_q <= 4'h0;
                     if (ack_q) begin
                        bst_q <= joy_pkg::B_TX;
                        sh_q  <= rd_byte;
                        oe_q  <= ~rd_byte[7];
                        ptr_q <= ptr_q + 8'h01;
                        if (ptr_q == `X_OFS || ptr_q == `Y_OFS) begin
                           coord_rd_q <= 1'b1;
                        end
                     end else begin
                        bst_q <= joy_pkg::B_IDLE;
                     end
                  end
               end
               default: begin
                  bst_q <= joy_pkg::B_IDLE;
                  oe_q  <= 1'b0;
               end
            endcase
         end
      end
   end
   assign sda_out    = 1'b0;
   assign sda_oe_out = oe_q;

   // Register writes; the soft clear bit acts for one cycle and reads back zero.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_q     <= `CTRL_RST;
         scale_q    <= `SCALE_RST;
         soft_clr_q <= 1'b0;
      end else if (clear) begin
         ctrl_q     <= `CTRL_RST;
         scale_q    <= `SCALE_RST;
         soft_clr_q <= 1'b0;
      end else begin
         if (wr_en && ready_q && ptr_q == `CTRL_OFS) begin
            ctrl_q     <= {sh_q[7:2], 2'b00};
            soft_clr_q <= sh_q[`CTRL_SOFT_BIT];
         end
         if (wr_en && ready_q && ptr_q == `SCALE_OFS) begin
            scale_q <= sh_q;
         end
      end
   end

   // Fresh data sets flag, and interrupt outside wake mode (there it loads the limit test); a set in the same cycle beats the clear.
   logic beyond;
   assign beyond = ($signed(x_meas_in) > $signed(WAKE_LIMIT)) ||
                   ($signed(x_meas_in) < -$signed(WAKE_LIMIT)) ||
                   ($signed(y_meas_in) > $signed(WAKE_LIMIT)) ||
                   ($signed(y_meas_in) < -$signed(WAKE_LIMIT));
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flag_q <= 1'b0;
         irq_q  <= 1'b0;
      end else if (clear) begin
         flag_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         if (new_data) begin
            flag_q <= 1'b1;
         end else if (y_read) begin
            flag_q <= 1'b0;
         end
         if (ctrl_q[`CTRL_MODE_BIT]) begin
            if (new_data) begin
               irq_q <= beyond;
            end
         end else if (new_data) begin
            irq_q <= 1'b1;
         end else if (y_read) begin
            irq_q <= 1'b0;
         end
      end
   end
   assign irq_out_low_out    = 1'b0;
   assign irq_out_low_oe_out = irq_q;
endmodule
`default_nettype wire

/* File: joy_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module joy_monitor #(
   parameter int START_CYC = 200,
   parameter int CONV_CYC  = 100
) (
   input wire logic       core_clk_in,
   input wire logic       rst_b_in,
   input wire logic       hw_clear_low_in,
   input wire logic       addr_sel_in,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   input wire logic       irq_out_low_out,
   input wire logic       irq_out_low_oe_out,
   input wire logic [7:0] x_meas_in,
   input wire logic [7:0] y_meas_in,
   input wire logic       meas_busy_out
);
   localparam int START_MAX = START_CYC + 8;
   localparam int CONV_MAX  = CONV_CYC + 4;
   localparam int PUA_MAX   = START_CYC + CONV_CYC + 24;
   default clocking mon_cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   sequence s_released; $rose(rst_b_in); endsequence
   sequence s_conv_start; $rose(meas_busy_out); endsequence
   property p_sda_od; sda_out == 1'b0; endproperty
   a_sda_od: assert property (p_sda_od) else $error("sda pin driven high");
   property p_irq_od; irq_out_low_out == 1'b0; endproperty
   a_irq_od: assert property (p_irq_od) else $error("irq pin driven high");
   property p_clear;
      (!hw_clear_low_in) [*5] |-> !meas_busy_out && !irq_out_low_oe_out && !sda_oe_out;
   endproperty
   a_clear: assert property (p_clear) else $error("clear pin did not clear state");
   property p_first_meas; s_released |-> ##[1:START_MAX] s_conv_start; endproperty
   a_first_meas: assert property (p_first_meas) else $error("no start-up measurement");
   property p_first_data; s_released |-> ##[1:PUA_MAX] irq_out_low_oe_out; endproperty
   a_first_data: assert property (p_first_data) else $error("first data late");
   property p_conv_time; s_conv_start |-> ##[1:CONV_MAX] !meas_busy_out; endproperty
   a_conv_time: assert property (p_conv_time) else $error("conversion too long");
   property p_irq_cause;
      $rose(irq_out_low_oe_out) |-> $past(meas_busy_out) || $past(meas_busy_out, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without new data");
   property p_oe_rise; $rose(sda_oe_out) |-> !scl_in; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("sda pulled with scl high");
   property p_oe_fall; $fell(sda_oe_out) |-> !scl_in; endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("sda freed with scl high");
endmodule
bind joy_encoder_ctrl joy_monitor #(.START_CYC(START_CYC), .CONV_CYC(CONV_CYC)) mon_u (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .hw_clear_low_in(hw_clear_low_in),
   .addr_sel_in(addr_sel_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_out(sda_oe_out), .irq_out_low_out(irq_out_low_out),
   .irq_out_low_oe_out(irq_out_low_oe_out), .x_meas_in(x_meas_in),
   .y_meas_in(y_meas_in), .meas_busy_out(meas_busy_out));
`default_nettype wire

/* File: joy_host.sv */
`timescale 1ns/1ns
`default_nettype none
module joy_host (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Half periods of four core cycles give an 80 ns bus clock.
   // The target answers three cycles after a fall, so its bit stands before the next rise.
   task automatic start_c;
      hold(1);
      sda_low_out <= 1'b0;
      hold(4);
      scl_out <= 1'b1;
      hold(8);
      sda_low_out <= 1'b1;
      hold(8);
      scl_out <= 1'b0;
      hold(4);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low_out <= ~b;
      hold(2);
      scl_out <= 1'b1;
      hold(2);
      r = sda_in;
      hold(2);
      scl_out <= 1'b0;
      hold(2);
   endtask
   // The ninth slot is always released, so the target's acknowledge can be seen.
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic stop_c;
      sda_low_out <= 1'b1;
      hold(4);
      scl_out <= 1'b1;
      hold(8);
      sda_low_out <= 1'b0;
      hold(8);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] r, output logic [7:0] q,
                     output logic ack);
      logic [7:0] q0;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       a3;
      start_c;
      byte_io({a, 1'b0}, q0, a0);
      byte_io(r, q0, a1);
      start_c;
      byte_io({a, 1'b1}, q0, a2);
      byte_io(8'hFF, q, a3);
      stop_c;
      ack = a0 & a1 & a2;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
                     output logic ack);
      logic [7:0] q0;
      logic       a0;
      logic       a1;
      logic       a2;
      start_c;
      byte_io({a, 1'b0}, q0, a0);
      byte_io(r, q0, a1);
      byte_io(d, q0, a2);
      stop_c;
      ack = a0 & a1 & a2;
   endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int START = 200;
   localparam int CONV  = 100;
   logic       core_clk_in = 1'b0;
   logic       rst_b_in = 1'b0;
   logic       hw_clear_low_in = 1'b1;
   logic       addr_sel_in = 1'b0;
   logic [7:0] x_meas_in = 8'h00;
   logic [7:0] y_meas_in = 8'h00;
   logic       scl_line;
   logic       host_low;
   logic       sda_line;
   logic       sda_out;
   logic       sda_oe_out;
   logic       irq_low;
   logic       irq_oe;
   logic       meas_busy_out;
   logic [7:0] rd_q;
   logic       ack_q;
   int         miscompares = 0;
   int         n_tests = 0;
   int         n;
   // A line nobody pulls floats up to the pull-up level.
   assign sda_line = ~(sda_oe_out | host_low);
   always #5 core_clk_in = ~core_clk_in;
   joy_encoder_ctrl #(.START_CYC(START), .CONV_CYC(CONV), .TB_UNIT_CYC(500)) dut_u (
      .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .hw_clear_low_in(hw_clear_low_in),
      .addr_sel_in(addr_sel_in), .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe_out(sda_oe_out), .irq_out_low_out(irq_low), .irq_out_low_oe_out(irq_oe),
      .x_meas_in(x_meas_in), .y_meas_in(y_meas_in), .meas_busy_out(meas_busy_out));
   joy_host host_u (.clk_in(core_clk_in), .sda_in(sda_line), .scl_out(scl_line),
                    .sda_low_out(host_low));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic poll_ready;
      for (int i = 0; i < 20; i++) begin
         host_u.rd(7'h40, 8'h0F, rd_q, ack_q);
         if ((rd_q & 8'hFE) === 8'hF0)
            break;
      end
      check(rd_q & 8'hFE, 8'hF0);
   endtask
   task automatic wait_busy(input logic lvl, input int lim);
      n = 0;
      while (meas_busy_out !== lvl && n < lim) begin
         @(negedge core_clk_in);
         n++;
      end
      if (meas_busy_out !== lvl) begin
         miscompares++;
         $display("unexpected at %0t: busy wait ran out", $time);
      end
   endtask
   initial begin
      repeat (10) @(posedge core_clk_in);
      check({5'h00, sda_oe_out, irq_oe, meas_busy_out}, 8'h00);
      rst_b_in <= 1'b1;
      n = 0;
      while (irq_oe !== 1'b1 && n < 2 * (START + CONV)) begin
         @(negedge core_clk_in);
         n++;
      end
      check({7'h00, n <= START + CONV + 24}, 8'h01);
      poll_ready;
      host_u.rd(7'h40, 8'h2D, rd_q, ack_q);
      check(rd_q, 8'h00);
      host_u.wr(7'h40, 8'h2D, 8'h0D, ack_q);
      check({7'h00, ack_q}, 8'h01);
      host_u.rd(7'h40, 8'h2D, rd_q, ack_q);
      check(rd_q, 8'h0D);
      for (int s = 0; s < 2; s++) begin
         addr_sel_in <= s[0];
         host_u.rd(7'h40 | 7'(s), 8'h0F, rd_q, ack_q);
         check({7'h00, ack_q}, 8'h01);
         host_u.rd(7'h41 - 7'(s), 8'h0F, rd_q, ack_q);
         check({7'h00, ack_q}, 8'h00);
      end
      addr_sel_in <= 1'b0;
      // Both ends of the signed range on x and both signs on y, so a sign or offset slip shows.
      for (int k = 0; k < 2; k++) begin
         x_meas_in <= k[0] ? 8'h7F : 8'h80;
         y_meas_in <= k[0] ? 8'h81 : 8'h01;
         host_u.rd(7'h40, 8'h10, rd_q, ack_q);
         wait_busy(1'b1, 50);
         wait_busy(1'b0, 46000);
         check({7'h00, n <= CONV + 16}, 8'h01);
         check({7'h00, irq_oe}, 8'h01);
         host_u.rd(7'h40, 8'h10, rd_q, ack_q);
         check(rd_q, k[0] ? 8'h7F : 8'h80);
         host_u.rd(7'h40, 8'h11, rd_q, ack_q);
         check(rd_q, k[0] ? 8'h81 : 8'h01);
         check({7'h00, irq_oe}, 8'h00);
      end
      // Wake mode: only a move past the limit, here on the negative side, raises it.
      host_u.wr(7'h40, 8'h0F, 8'h84, ack_q);
      for (int k = 0; k < 2; k++) begin
         x_meas_in <= k[0] ? 8'hE0 : 8'h05;
         y_meas_in <= 8'h00;
         host_u.rd(7'h40, 8'h10, rd_q, ack_q);
         wait_busy(1'b1, 50);
         wait_busy(1'b0, 200);
         check({7'h00, irq_oe}, {7'h00, k[0]});
      end
      // With idle off the timebase starts a measurement with no bus read at all.
      host_u.wr(7'h40, 8'h0F, 8'h00, ack_q);
      wait_busy(1'b1, 600);
      check({7'h00, meas_busy_out}, 8'h01);
      hw_clear_low_in <= 1'b0;
      repeat (20) @(posedge core_clk_in);
      hw_clear_low_in <= 1'b1;
      poll_ready;
      host_u.rd(7'h40, 8'h2D, rd_q, ack_q);
      check(rd_q, 8'h00);
      tally_and_finish;
   end
   // About twenty bus transfers of up to some 360 cycles each fit well inside 400 us.
   initial begin
      #400000;
      miscompares++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
